// ---- hw/aeqs_pkg.sv ----
// Constants for the adaptive equalizer search controller
package aeqs_pkg;
   // Register offsets
   localparam logic [7:0] CTL_ONE_OFS    = 8'h35;
   localparam logic [7:0] ADAPTED_OFS    = 8'h3B;
   localparam logic [7:0] CTL_TWO_OFS    = 8'h45;
   // Control one fields
   localparam int         RESTART_BIT    = 0;
   localparam int         FLOOR_APPLY_BIT = 1;
   localparam int         FLOOR_OVR_BIT  = 2;
   // Control two fields: floor value in [7:4], dwell code in [2:0]
   localparam int         FLOOR_LSB      = 4;
   localparam int         DWELL_LSB      = 0;
   localparam int         DWELL_CODE_W   = 3;
   // Status fields
   localparam int         HOLDING_BIT    = 7;
   // Values after reset
   localparam logic [7:0] CTL_ONE_RST    = 8'h00;
   localparam logic [7:0] CTL_TWO_RST    = 8'h03;
   // Dwell interval is (code + 1) units; reset code 3 gives 2.62 ms
   localparam int         CLK_PERIOD_NS  = 40;
   localparam int         DWELL_DEF_NS   = 2620000;
   localparam int         DWELL_UNIT_NS  = DWELL_DEF_NS / (int'(CTL_TWO_RST[2:0]) + 1);
   localparam int         DWELL_UNIT_CYC = DWELL_UNIT_NS / CLK_PERIOD_NS;
   localparam int         CNT_W          = 20;
   typedef enum logic {AEQS_DWELL, AEQS_HOLD} aeqs_state_t;
endpackage

// ---- hw/aeqs_search.sv ----
// Adaptive equalizer gain search with dwell timer and control registers
`timescale 1ns/1ns
`default_nettype none
module aeqs_search #(
   parameter int GAIN_W    = 4,
   parameter int DWELL_UNIT = aeqs_pkg::DWELL_UNIT_CYC
) (
   // Clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   // Register port from serial control logic
   input  wire logic              i_reg_wr,
   input  wire logic              i_reg_rd,
   input  wire logic [7:0]        i_reg_addr,
   input  wire logic [7:0]        i_reg_wdata,
   output logic      [7:0]        o_reg_rdata,
   // Soft reset pulse and recovered lock pin
   input  wire logic              i_logic_soft_reset,
   input  wire logic              i_cdr_lock,
   // Gain to the analog equalizer, and hold flag
   output logic      [GAIN_W-1:0] o_eq_gain,
   output logic                   o_eq_holding
);
   localparam logic [GAIN_W-1:0] GAIN_MAX = '1;
   localparam logic [GAIN_W-1:0] GAIN_MIN = '0;

   function automatic logic [GAIN_W-1:0] next_gain(input logic [GAIN_W-1:0] g,
                                                   input logic [GAIN_W-1:0] s);
      next_gain = (g == GAIN_MAX) ? s : g + 1'b1;
   endfunction

   // Lock pin crosses into the core clock
   logic lock_m_q;
   logic lock_s_q;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         lock_m_q <= 1'b0;
         lock_s_q <= 1'b0;
      end else begin
         lock_m_q <= i_cdr_lock;
         lock_s_q <= lock_m_q;
      end
   end

   // Search state
   aeqs_pkg::aeqs_state_t      state_q, state_d;
   logic [GAIN_W-1:0]           gain_q, gain_d, gain_next;
   logic                        holding_q, holding_d;
   logic [aeqs_pkg::CNT_W-1:0] cnt_q, cnt_d, dwell_len;
   logic                        dwell_done;

   // Registers
   logic [7:0]        ctl1_q, ctl1_d, ctl2_q, ctl2_d, rdata_q, rdata_d;
   logic              restart;
   logic [GAIN_W-1:0] start_gain, floor_val;
   always_comb begin
      ctl1_d  = ctl1_q;
      ctl2_d  = ctl2_q;
      rdata_d = rdata_q;
      if (i_reg_wr && i_reg_addr == aeqs_pkg::CTL_ONE_OFS) begin
         ctl1_d = i_reg_wdata;
      end
      if (i_reg_wr && i_reg_addr == aeqs_pkg::CTL_TWO_OFS) begin
         ctl2_d = i_reg_wdata;
      end
      // Restart bit never stays set
      ctl1_d[aeqs_pkg::RESTART_BIT] = 1'b0;
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            aeqs_pkg::CTL_ONE_OFS: rdata_d = ctl1_q;
            aeqs_pkg::CTL_TWO_OFS: rdata_d = ctl2_q;
            aeqs_pkg::ADAPTED_OFS: begin
               rdata_d = 8'h00;
               rdata_d[GAIN_W-1:0] = gain_q;
               rdata_d[aeqs_pkg::HOLDING_BIT] = holding_q;
            end
            default:               rdata_d = 8'h00;
         endcase
      end
   end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ctl1_q  <= aeqs_pkg::CTL_ONE_RST;
         ctl2_q  <= aeqs_pkg::CTL_TWO_RST;
         rdata_q <= 8'h00;
      end else begin
         ctl1_q  <= ctl1_d;
         ctl2_q  <= ctl2_d;
         rdata_q <= rdata_d;
      end
   end

   // New floor settings count at once, so one write can set floor and restart
   assign restart = i_logic_soft_reset ||
                    (i_reg_wr && i_reg_addr == aeqs_pkg::CTL_ONE_OFS &&
                     i_reg_wdata[aeqs_pkg::RESTART_BIT]);
   assign floor_val  = ctl2_d[aeqs_pkg::FLOOR_LSB +: GAIN_W];
   assign start_gain = (ctl1_d[aeqs_pkg::FLOOR_OVR_BIT] && ctl1_d[aeqs_pkg::FLOOR_APPLY_BIT])
                       ? floor_val : GAIN_MIN;

   // Dwell timer and next gain
   assign dwell_len  = aeqs_pkg::CNT_W'((int'(ctl2_q[aeqs_pkg::DWELL_LSB +: aeqs_pkg::DWELL_CODE_W]) + 1)
                       * DWELL_UNIT);
   // Compare with >= so a shorter code written mid-dwell ends it at once
   assign dwell_done = (cnt_q >= dwell_len - 1'b1);
   // Step value seen by the checks
   assign gain_next  = next_gain(gain_q, start_gain);

   always_comb begin
      state_d = state_q;
      gain_d  = gain_q;
      cnt_d   = cnt_q;
      if (restart) begin
         state_d = aeqs_pkg::AEQS_DWELL;
         gain_d  = start_gain;
         cnt_d   = '0;
      end else begin
         unique case (state_q)
            aeqs_pkg::AEQS_DWELL: begin
               if (!dwell_done) begin
                  cnt_d = cnt_q + 1'b1;
               end else if (lock_s_q) begin
                  state_d = aeqs_pkg::AEQS_HOLD;
               end else begin
                  // Fixed top of range, wrap to start
                  gain_d = next_gain(gain_q, start_gain);
                  cnt_d  = '0;
               end
            end
            aeqs_pkg::AEQS_HOLD: begin
               if (!lock_s_q) begin
                  state_d = aeqs_pkg::AEQS_DWELL;
                  gain_d  = next_gain(gain_q, start_gain);
                  cnt_d   = '0;
               end
            end
         endcase
      end
      // Registered flag keeps the pin glitch free
      holding_d = (state_d == aeqs_pkg::AEQS_HOLD);
   end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= aeqs_pkg::AEQS_DWELL;
         gain_q  <= '0;
         cnt_q   <= '0;
         holding_q <= 1'b0;
      end else begin
         state_q <= state_d;
         gain_q  <= gain_d;
         cnt_q   <= cnt_d;
         holding_q <= holding_d;
      end
   end

   assign o_eq_gain    = gain_q;
   assign o_eq_holding = holding_q;
   assign o_reg_rdata  = rdata_q;

   // Checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   AST_HOLD_ONLY_AFTER_DWELL: assert property (
      $rose(o_eq_holding) |-> $past(dwell_done) && $past(lock_s_q))
      else $error("hold entered before dwell ended");
   AST_HOLD_KEEPS_GAIN: assert property (
      o_eq_holding && lock_s_q && !restart |=> o_eq_holding && $stable(gain_q))
      else $error("held gain changed while locked");
   AST_LOSS_ADVANCES: assert property (
      o_eq_holding && !lock_s_q && !restart |=> !o_eq_holding && cnt_q == '0 &&
      gain_q == $past(gain_next))
      else $error("lock loss did not advance gain");
   AST_RESTART_RELOADS: assert property (
      restart |=> !o_eq_holding && cnt_q == '0 && gain_q == $past(start_gain))
      else $error("restart did not reload start gain");
   AST_SEARCH_STEPS: assert property (
      !o_eq_holding && dwell_done && !lock_s_q && !restart |=>
      gain_q == $past(gain_next) && cnt_q == '0)
      else $error("search did not step after dwell");
   AST_FLOOR_GATED: assert property (
      restart && !(ctl1_d[aeqs_pkg::FLOOR_OVR_BIT] && ctl1_d[aeqs_pkg::FLOOR_APPLY_BIT])
      |=> gain_q == GAIN_MIN)
      else $error("floor used while not enabled");
   AST_WRAP_AT_MAX: assert property (
      !o_eq_holding && gain_q == GAIN_MAX && dwell_done && !lock_s_q && !restart
      |=> gain_q == $past(start_gain))
      else $error("no wrap at maximum gain");
   AST_STATUS_READ: assert property (
      i_reg_rd && i_reg_addr == aeqs_pkg::ADAPTED_OFS |=> o_reg_rdata[GAIN_W-1:0] == $past(gain_q))
      else $error("status does not show gain");
   AST_DWELL_BOUND: assert property (
      !o_eq_holding && !restart && cnt_q < dwell_len - 1'b1 |=> !o_eq_holding)
      else $error("dwell cut short");
   AST_FLOOR_LOADS: assert property (
      restart && ctl1_d[aeqs_pkg::FLOOR_OVR_BIT] && ctl1_d[aeqs_pkg::FLOOR_APPLY_BIT]
      |=> gain_q == $past(floor_val))
      else $error("restart ignored enabled floor");
   AST_SOFT_RESET: assert property (
      i_logic_soft_reset |=> !o_eq_holding && cnt_q == '0 && gain_q == $past(start_gain))
      else $error("soft reset did not restart search");
   CVR_LOCK_HOLD:  cover property (o_eq_holding ##1 !lock_s_q ##1 !o_eq_holding);
   CVR_WRAP:       cover property (gain_q == GAIN_MAX ##1 gain_q == GAIN_MIN);
   CVR_FLOOR_RST:  cover property (restart && start_gain != GAIN_MIN);
   CVR_SOFT_RST:   cover property (i_logic_soft_reset ##1 cnt_q == '0);
   CVR_HELD_READ:  cover property (i_reg_rd && i_reg_addr == aeqs_pkg::ADAPTED_OFS && o_eq_holding);
endmodule
`default_nettype wire

// ---- tb/aeqs_lock_model.sv ----
// Lock detector model that locks when the gain matches a chosen value
`timescale 1ns/1ns
`default_nettype none
module aeqs_lock_model (
   // Clock
   input  wire logic       i_core_clk,
   // Lock target set by the bench
   input  wire logic       i_lock_en,
   input  wire logic [3:0] i_lock_gain,
   // Gain and lock
   input  wire logic [3:0] i_eq_gain,
   output logic            o_cdr_lock
);
   // Registered, so lock trails a gain change as a real detector does
   always_ff @(posedge i_core_clk) begin
      o_cdr_lock <= i_lock_en && (i_eq_gain == i_lock_gain);
   end
endmodule
`default_nettype wire

// ---- tb/aeqs_search_test.sv ----
// Self-checking bench for the equalizer gain search
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %0t: got %h exp %h", $time, g, e); end end
module aeqs_search_test;
   logic       i_core_clk = 0;
   logic       i_rst = 1;
   logic       i_reg_wr = 0;
   logic       i_reg_rd = 0;
   logic [7:0] i_reg_addr = 8'h00;
   logic [7:0] i_reg_wdata = 8'h00;
   logic [7:0] o_reg_rdata;
   logic       i_logic_soft_reset = 0;
   logic       cdr_lock;
   logic       lock_en = 0;
   logic [3:0] lock_gain = 4'h0;
   logic [3:0] o_eq_gain;
   logic       o_eq_holding;
   logic [7:0] q;
   int         errors = 0;
   int         compares = 0;
   int         cyc = 0;
   // Address, write data, expected read back
   logic [23:0] rows [6] = '{24'h45_5b5b, 24'h35_f6f6, 24'h10_5500, 24'h45_0303, 24'h35_0100, 24'h3b_ff00};

   aeqs_search #(.DWELL_UNIT(4)) u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .i_logic_soft_reset(i_logic_soft_reset), .i_cdr_lock(cdr_lock), .o_eq_gain(o_eq_gain),
      .o_eq_holding(o_eq_holding));
   aeqs_lock_model u_lock (.i_core_clk(i_core_clk), .i_lock_en(lock_en), .i_lock_gain(lock_gain),
      .i_eq_gain(o_eq_gain), .o_cdr_lock(cdr_lock));

   initial begin
      forever #20 i_core_clk = ~i_core_clk;
   end

   task automatic w(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_core_clk);
      i_reg_wr = 1;
      i_reg_addr = a;
      i_reg_wdata = d;
      @(negedge i_core_clk);
      i_reg_wr = 0;
   endtask
   // Data is sampled two edges after the strobe, once it has surely settled
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_core_clk);
      i_reg_rd = 1;
      i_reg_addr = a;
      @(negedge i_core_clk);
      i_reg_rd = 0;
      w(1);
      d = o_reg_rdata;
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic summarize();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 4000) begin
         errors++;
         summarize();
      end
   end

   initial begin
      w(8);
      i_rst = 0;
      rd(8'h45, q);
      `CHK(q, 8'h03)
      rd(8'h3b, q);
      `CHK(q, 8'h00)
      done("reset");
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], q);
         `CHK(q, rows[i][7:0])
      end
      done("registers");
      wr(8'h35, 8'h01);
      w(15);
      `CHK(o_eq_gain, 4'h0)
      w(1);
      `CHK(o_eq_gain, 4'h1)
      w(239);
      `CHK(o_eq_gain, 4'hf)
      w(1);
      `CHK(o_eq_gain, 4'h0)
      done("sweep");
      wr(8'h45, 8'ha3);
      wr(8'h35, 8'h07);
      w(15);
      `CHK(o_eq_gain, 4'ha)
      w(80);
      `CHK(o_eq_gain, 4'hf)
      w(1);
      `CHK(o_eq_gain, 4'ha)
      for (int i = 0; i < 2; i++) begin
         wr(8'h35, i ? 8'h03 : 8'h05);
         w(8);
         `CHK(o_eq_gain, 4'h0)
      end
      done("floor");
      wr(8'h45, 8'h03);
      lock_gain = 4'h3;
      lock_en = 1;
      wr(8'h35, 8'h01);
      w(80);
      `CHK({o_eq_holding, o_eq_gain}, 5'h13)
      w(100);
      `CHK({o_eq_holding, o_eq_gain}, 5'h13)
      rd(8'h3b, q);
      `CHK(q, 8'h83)
      wr(8'h35, 8'h01);
      `CHK({o_eq_holding, o_eq_gain}, 5'h00)
      w(80);
      lock_en = 0;
      w(6);
      `CHK({o_eq_holding, o_eq_gain}, 5'h04)
      done("lock");
      wr(8'h45, 8'h00);
      wr(8'h35, 8'h01);
      w(3);
      `CHK(o_eq_gain, 4'h0)
      w(1);
      `CHK(o_eq_gain, 4'h1)
      w(2);
      i_logic_soft_reset = 1;
      w(1);
      i_logic_soft_reset = 0;
      w(3);
      `CHK(o_eq_gain, 4'h0)
      w(1);
      `CHK(o_eq_gain, 4'h1)
      done("dwell");
      summarize();
   end
endmodule
`default_nettype wire
